// ---- design/spi_map_pkg.sv ----
// Constants, types and reset values for the serial register map
package spi_map_pkg;
  localparam int NREG = 35;
  localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
  localparam logic [12:0] ADDR_CHIP_ID = 13'h001;
  localparam logic [12:0] ADDR_GRADE = 13'h002;
  localparam logic [12:0] ADDR_CHAN = 13'h005;
  localparam logic [12:0] ADDR_XFER = 13'h0ff;
  localparam logic [12:0] ADDR_FUNC_LO = 13'h008;
  localparam logic [12:0] ADDR_SHADOW_HI = 13'h020;
  localparam logic [12:0] ADDR_FUNC_HI = 13'h025;
  localparam logic [12:0] ADDR_FEAT_LO = 13'h03a;
  localparam logic [12:0] ADDR_FEAT_HI = 13'h03e;
  localparam logic [5:0] FEAT_IDX_BASE = 6'h1e;
  localparam logic [5:0] IDX_CLOCK = 6'h01;
  localparam logic [5:0] IDX_OUTMODE = 6'h0c;
  localparam logic [7:0] CLOCK_RST = 8'h01;
  localparam logic [7:0] OUTMODE_RST = 8'h05;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [1:0] CHAN_RST = 2'h3;
  localparam logic [7:0] XFER_CMD = 8'h01;
  // Only the clock register is shared; every other bank entry is per channel
  localparam logic [NREG-1:0] GLOBAL_MASK = 35'h000000002;
  localparam int PC_LSB_HI = 6;
  localparam int PC_LSB_LO = 1;
  localparam int PC_SR_HI = 5;
  localparam int PC_SR_LO = 2;
  localparam int INSTR_RW = 15;
  localparam int INSTR_LEN_HI = 14;
  localparam int INSTR_LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_INSTR = 2'b01, ST_DATA = 2'b11, ST_HOLD = 2'b10} frame_e;
  typedef enum logic [2:0] {K_NONE, K_PORT, K_ID, K_GRADE, K_CHAN, K_XFER, K_BANK} kind_e;
  typedef logic [NREG-1:0][7:0] bank_t;
  typedef struct packed {kind_e kind; logic [5:0] idx;} decode_s;
  typedef struct packed {
    logic [2:0] csn_sync; logic [2:0] sclk_sync; logic [2:0] sdio_sync;
    logic csn_lvl; logic sclk_lvl; logic din_lvl;
    frame_e state; logic [3:0] bit_cnt; logic [15:0] shreg; logic [12:0] addr;
    logic is_read; logic [1:0] length; logic [1:0] byte_cnt; logic [7:0] tx;
    logic sdio_out; logic sdio_oe_n; logic lsb_first; logic [1:0] chan_sel; logic xfer;
    logic [1:0][NREG-1:0][7:0] hold; logic [1:0][NREG-1:0][7:0] active;
  } state_s;

  function automatic bank_t bank_default();
    bank_t b;
    b = '0;
    b[IDX_CLOCK] = CLOCK_RST;
    b[IDX_OUTMODE] = OUTMODE_RST;
    return b;
  endfunction

  localparam bank_t BANK_RST = bank_default();
  localparam state_s STATE_RST = '{csn_sync: 3'h7, sclk_sync: 3'h0, sdio_sync: 3'h0, csn_lvl: 1'b1,
    sclk_lvl: 1'b0, din_lvl: 1'b0, state: ST_IDLE, bit_cnt: 4'h0, shreg: 16'h0000, addr: 13'h0000,
    is_read: 1'b0, length: 2'h0, byte_cnt: 2'h0, tx: 8'h00, sdio_out: 1'b0, sdio_oe_n: 1'b1,
    lsb_first: 1'b0, chan_sel: CHAN_RST, xfer: 1'b0, hold: {BANK_RST, BANK_RST},
    active: {BANK_RST, BANK_RST}};
endpackage

// ---- design/serial_register_map_shadow.sv ----
// Three-wire serial slave with shadowed, per-channel register map
`timescale 1ns/1ps
module serial_register_map_shadow
  import spi_map_pkg::*;
#(
  // Arbitrary neutral value
  parameter logic [7:0] CHIP_ID = 8'h5a,
  parameter logic [1:0] SPEED_GRADE = 2'h0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output bank_t active_a,
  output bank_t active_b
);

  state_s r_ff;
  state_s nxt_r;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_en;
  decode_s rd_dec;
  logic [7:0] wr_data;
  logic soft_hit;
  decode_s wr_dec;

  // Address decode by range
  function automatic decode_s decode(input logic [12:0] a);
    decode_s d;
    d.kind = K_NONE;
    d.idx = 6'h00;
    if (a == ADDR_PORT_CFG) d.kind = K_PORT;
    else if (a == ADDR_CHIP_ID) d.kind = K_ID;
    else if (a == ADDR_GRADE) d.kind = K_GRADE;
    else if (a == ADDR_CHAN) d.kind = K_CHAN;
    else if (a == ADDR_XFER) d.kind = K_XFER;
    else if (a >= ADDR_FUNC_LO && a <= ADDR_FUNC_HI) begin
      d.kind = K_BANK;
      d.idx = 6'(a - ADDR_FUNC_LO);
    end else if (a >= ADDR_FEAT_LO && a <= ADDR_FEAT_HI) begin
      d.kind = K_BANK;
      d.idx = 6'(a - ADDR_FEAT_LO) + FEAT_IDX_BASE;
    end
    return d;
  endfunction

  function automatic logic shadowed(input logic [5:0] idx);
    return (idx <= 6'(ADDR_SHADOW_HI - ADDR_FUNC_LO)) || (idx >= FEAT_IDX_BASE);
  endfunction

  function automatic logic [7:0] read_byte(input state_s s, input logic [12:0] a);
    decode_s d;
    d = decode(a);
    case (d.kind)
      // mirrored readback, soft reset reads clear
      K_PORT: read_byte = {1'b0, s.lsb_first, 1'b0, 1'b1, 1'b1, 1'b0, s.lsb_first, 1'b0};
      K_ID: read_byte = CHIP_ID;
      K_GRADE: read_byte = {2'h0, SPEED_GRADE, 4'h0};
      K_CHAN: read_byte = {6'h00, s.chan_sel};
      K_XFER: read_byte = {7'h00, s.xfer};
      // channel B only when it alone is selected
      K_BANK: read_byte = (!GLOBAL_MASK[d.idx] && s.chan_sel == 2'b10) ? s.hold[1][d.idx] : s.hold[0][d.idx];
      default: read_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    nxt_r = r_ff;
    wr_en = 1'b0;
    wr_data = 8'h00;
    soft_hit = 1'b0;
    wr_dec = decode(r_ff.addr);
    // Three-stage pin sampling, change accepted when stages two and three agree
    nxt_r.csn_sync = {r_ff.csn_sync[1:0], chip_select_n};
    nxt_r.sclk_sync = {r_ff.sclk_sync[1:0], sclk};
    nxt_r.sdio_sync = {r_ff.sdio_sync[1:0], sdio_in};
    if (r_ff.csn_sync[1] == r_ff.csn_sync[2]) nxt_r.csn_lvl = r_ff.csn_sync[2];
    if (r_ff.sclk_sync[1] == r_ff.sclk_sync[2]) nxt_r.sclk_lvl = r_ff.sclk_sync[2];
    if (r_ff.sdio_sync[1] == r_ff.sdio_sync[2]) nxt_r.din_lvl = r_ff.sdio_sync[2];
    sclk_rise = nxt_r.sclk_lvl & ~r_ff.sclk_lvl;
    sclk_fall = ~nxt_r.sclk_lvl & r_ff.sclk_lvl;

    // one-cycle copy of every shadowed entry
    if (r_ff.xfer) begin
      for (int ch = 0; ch < 2; ch++) begin
        for (int i = 0; i < NREG; i++) begin
          if (shadowed(6'(i))) nxt_r.active[ch][i] = r_ff.hold[ch][i];
        end
      end
      nxt_r.xfer = 1'b0;
    end

    if (nxt_r.csn_lvl) begin
      nxt_r.state = ST_IDLE;
      nxt_r.sdio_oe_n = 1'b1;
    end else if (r_ff.csn_lvl) begin
      nxt_r.state = ST_INSTR;
      nxt_r.bit_cnt = 4'h0;
      nxt_r.sdio_oe_n = 1'b1;
    end else begin
      if (sclk_rise && (r_ff.state == ST_INSTR || r_ff.state == ST_DATA)) begin
        // shift order follows the port configuration
        nxt_r.shreg = r_ff.lsb_first ? {nxt_r.din_lvl, r_ff.shreg[15:1]} : {r_ff.shreg[14:0], nxt_r.din_lvl};
        nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
        if (r_ff.state == ST_INSTR && r_ff.bit_cnt == 4'hf) begin
          nxt_r.is_read = nxt_r.shreg[INSTR_RW];
          nxt_r.length = nxt_r.shreg[INSTR_LEN_HI:INSTR_LEN_LO];
          nxt_r.addr = nxt_r.shreg[12:0];
          nxt_r.byte_cnt = 2'h0;
          nxt_r.bit_cnt = 4'h0;
          nxt_r.state = ST_DATA;
          nxt_r.tx = read_byte(r_ff, nxt_r.shreg[12:0]);
        end else if (r_ff.state == ST_DATA && r_ff.bit_cnt == 4'h7) begin
          nxt_r.bit_cnt = 4'h0;
          if (!r_ff.is_read) begin
            wr_en = 1'b1;
            wr_data = r_ff.lsb_first ? nxt_r.shreg[15:8] : nxt_r.shreg[7:0];
          end
          // Streaming walks down in MSB-first order, up in LSB-first order
          nxt_r.addr = r_ff.lsb_first ? r_ff.addr + 13'h0001 : r_ff.addr - 13'h0001;
          nxt_r.byte_cnt = r_ff.byte_cnt + 2'h1;
          nxt_r.tx = read_byte(r_ff, nxt_r.addr);
          if (r_ff.length != LEN_STREAM && r_ff.byte_cnt == r_ff.length) nxt_r.state = ST_HOLD;
        end
      end
      // drive read data on falling edges after the instruction
      if (sclk_fall && r_ff.state == ST_DATA && r_ff.is_read) begin
        nxt_r.sdio_out = r_ff.lsb_first ? r_ff.tx[0] : r_ff.tx[7];
        nxt_r.tx = r_ff.lsb_first ? {1'b0, r_ff.tx[7:1]} : {r_ff.tx[6:0], 1'b0};
        nxt_r.sdio_oe_n = 1'b0;
      end
    end

    if (wr_en) begin
      case (wr_dec.kind)
        K_PORT: begin
          nxt_r.lsb_first = wr_data[PC_LSB_HI] | wr_data[PC_LSB_LO];
          soft_hit = wr_data[PC_SR_HI] | wr_data[PC_SR_LO];
        end
        K_CHAN: nxt_r.chan_sel = wr_data[1:0];
        // Set placed after the autoclear so a new command is never lost
        K_XFER: if (wr_data == XFER_CMD) nxt_r.xfer = 1'b1;
        K_BANK: begin
          for (int ch = 0; ch < 2; ch++) begin
            // steer by index bits; both; global both
            if (GLOBAL_MASK[wr_dec.idx] || r_ff.chan_sel[ch]) begin
              // holding copy for every entry; active copy written at once only for unshadowed entries
              nxt_r.hold[ch][wr_dec.idx] = wr_data;
              if (!shadowed(wr_dec.idx)) nxt_r.active[ch][wr_dec.idx] = wr_data;
            end
          end
        end
        // Unsupported addresses are left untouched
        default: ;
      endcase
    end

    if (soft_hit) begin
      nxt_r.hold = {BANK_RST, BANK_RST};
      nxt_r.active = {BANK_RST, BANK_RST};
      nxt_r.chan_sel = CHAN_RST;
      nxt_r.lsb_first = 1'b0;
      nxt_r.xfer = 1'b0;
    end
    rd_dec = decode(nxt_r.shreg[12:0]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_ff <= STATE_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sdio_out = r_ff.sdio_out;
  assign sdio_oe_n = r_ff.sdio_oe_n;
  assign active_a = r_ff.active[0];
  assign active_b = r_ff.active[1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_frame_open;
    $fell(r_ff.csn_lvl) ##0 !nxt_r.csn_lvl;
  endsequence
  sequence s_instr_ready;
    r_ff.state == ST_INSTR && r_ff.bit_cnt == 4'h0;
  endsequence
  sequence s_last_instr_bit;
    r_ff.state == ST_INSTR && r_ff.bit_cnt == 4'hf && sclk_rise && !nxt_r.csn_lvl;
  endsequence
  sequence s_shift_edge;
    sclk_rise && !nxt_r.csn_lvl && !r_ff.csn_lvl && (r_ff.state == ST_INSTR || r_ff.state == ST_DATA);
  endsequence
  sequence s_read_fall;
    sclk_fall && !nxt_r.csn_lvl && !r_ff.csn_lvl && r_ff.state == ST_DATA && r_ff.is_read;
  endsequence

  a_frame_start: assert property (s_frame_open |=> s_instr_ready)
    else $error("frame did not open on select low");
  a_instr_done: assert property (s_last_instr_bit |=>
      r_ff.state == ST_DATA && r_ff.bit_cnt == 4'h0)
    else $error("instruction phase not 16 bits");
  a_frame_idle: assert property (nxt_r.csn_lvl |=> r_ff.state == ST_IDLE)
    else $error("frame state not idle after select high");
  a_hold_refuse: assert property (r_ff.state == ST_HOLD && !nxt_r.csn_lvl |=>
      r_ff.state == ST_HOLD)
    else $error("bits accepted after the byte count");
  a_msb_shift: assert property (s_shift_edge ##0 !r_ff.lsb_first |=>
      r_ff.shreg[0] == $past(nxt_r.din_lvl))
    else $error("msb-first bit not shifted in at the bottom");
  a_lsb_shift: assert property (s_shift_edge ##0 r_ff.lsb_first |=>
      r_ff.shreg[15] == $past(nxt_r.din_lvl))
    else $error("lsb-first bit not shifted in at the top");
  a_xfer_clear: assert property (r_ff.xfer && !(wr_en && wr_dec.kind == K_XFER) |=> !r_ff.xfer)
    else $error("transfer bit did not clear");
  a_xfer_set: assert property (wr_en && wr_dec.kind == K_XFER && wr_data == XFER_CMD |=> r_ff.xfer)
    else $error("transfer command not taken");
  a_xfer_copy: assert property (r_ff.xfer && !soft_hit |=>
      r_ff.active[0][0] == $past(r_ff.hold[0][0]) && r_ff.active[1][NREG-1] == $past(r_ff.hold[1][NREG-1]))
    else $error("transfer did not copy holding values");
  a_shadow_hold: assert property (!r_ff.xfer && !soft_hit |=>
      $stable(r_ff.active[0][0]) && $stable(r_ff.active[1][NREG-1]))
    else $error("shadowed entry changed without transfer");
  a_unshadow_now: assert property (wr_en && wr_dec.kind == K_BANK && !shadowed(wr_dec.idx) &&
      r_ff.chan_sel[1] && !soft_hit |=> r_ff.active[1][$past(wr_dec.idx)] == $past(wr_data))
    else $error("unshadowed entry did not act at once");
  a_steer_a: assert property (wr_en && wr_dec.kind == K_BANK && r_ff.chan_sel == 2'b01 &&
      !GLOBAL_MASK[wr_dec.idx] && !soft_hit |=> r_ff.hold[0][$past(wr_dec.idx)] == $past(wr_data) &&
      r_ff.hold[1][$past(wr_dec.idx)] == $past(r_ff.hold[1][wr_dec.idx]))
    else $error("channel A write reached the wrong copy");
  a_steer_b: assert property (wr_en && wr_dec.kind == K_BANK && r_ff.chan_sel == 2'b10 &&
      !GLOBAL_MASK[wr_dec.idx] && !soft_hit |=> r_ff.hold[1][$past(wr_dec.idx)] == $past(wr_data) &&
      r_ff.hold[0][$past(wr_dec.idx)] == $past(r_ff.hold[0][wr_dec.idx]))
    else $error("channel B write reached the wrong copy");
  a_global_both: assert property (wr_en && wr_dec.kind == K_BANK && GLOBAL_MASK[wr_dec.idx] &&
      !soft_hit |=> r_ff.hold[0][$past(wr_dec.idx)] == $past(wr_data) &&
      r_ff.hold[1][$past(wr_dec.idx)] == $past(wr_data))
    else $error("global write not seen by both copies");
  a_both_write: assert property (wr_en && wr_dec.kind == K_BANK && r_ff.chan_sel == 2'b11 && !soft_hit |=>
      r_ff.hold[0][$past(wr_dec.idx)] == r_ff.hold[1][$past(wr_dec.idx)])
    else $error("both-channel write left copies different");
  a_read_both: assert property (s_last_instr_bit ##0 (nxt_r.shreg[INSTR_RW] && rd_dec.kind == K_BANK &&
      r_ff.chan_sel == 2'b11) |=> r_ff.tx == $past(r_ff.hold[0][rd_dec.idx]))
    else $error("both-select read did not return channel A");
  a_read_b: assert property (s_last_instr_bit ##0 (nxt_r.shreg[INSTR_RW] && rd_dec.kind == K_BANK &&
      !GLOBAL_MASK[rd_dec.idx] && r_ff.chan_sel == 2'b10) |=> r_ff.tx == $past(r_ff.hold[1][rd_dec.idx]))
    else $error("channel B read did not return its copy");
  a_index_now: assert property (wr_en && wr_dec.kind == K_CHAN && !soft_hit |=>
      r_ff.chan_sel == $past(wr_data[1:0]))
    else $error("channel index not updated at once");
  a_port_mirror: assert property (wr_en && wr_dec.kind == K_PORT && !soft_hit |=>
      r_ff.lsb_first == ($past(wr_data[PC_LSB_HI]) | $past(wr_data[PC_LSB_LO])))
    else $error("bit order control not mirrored");
  a_soft_defaults: assert property (soft_hit |=> r_ff.chan_sel == CHAN_RST && !r_ff.lsb_first &&
      !r_ff.xfer && r_ff.active[0][IDX_CLOCK] == CLOCK_RST && r_ff.active[1][IDX_OUTMODE] == OUTMODE_RST)
    else $error("soft reset did not restore defaults");
  a_drive_msb: assert property (s_read_fall ##0 !r_ff.lsb_first |=>
      !r_ff.sdio_oe_n && r_ff.sdio_out == $past(r_ff.tx[7]))
    else $error("read bit not driven msb first");
  a_drive_lsb: assert property (s_read_fall ##0 r_ff.lsb_first |=>
      !r_ff.sdio_oe_n && r_ff.sdio_out == $past(r_ff.tx[0]))
    else $error("read bit not driven lsb first");
  a_write_quiet: assert property (r_ff.state == ST_DATA && !r_ff.is_read |-> r_ff.sdio_oe_n)
    else $error("data pin driven during write data");
  a_quiet_instr: assert property (r_ff.state == ST_INSTR || r_ff.csn_lvl |-> r_ff.sdio_oe_n)
    else $error("data pin driven outside read data");
  a_release_pin: assert property (nxt_r.csn_lvl |=> r_ff.sdio_oe_n [*1])
    else $error("data pin not released at frame end");
endmodule

// ---- bench/spi_host.sv ----
// Serial master model for the three-wire register port
`timescale 1ns/1ps
module spi_host (
  input wire logic ref_clk,
  output logic sclk,
  output logic chip_select_n,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  output logic line
);
  logic drv = 1'b1;
  logic bit_val = 1'b0;
  logic flip = 1'b0;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
  end
  // Released line toggles, never a stale value
  always @(posedge ref_clk) begin
    flip <= ~flip;
  end
  assign line = !dev_oe_n ? dev_out : (drv ? bit_val : flip);
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic frame(input logic [15:0] ins, input logic [7:0] wd, input logic lsb, output logic [7:0] rd);
    logic [23:0] word;
    // Send order follows the device's bit order
    for (int k = 0; k < 16; k++) word[23-k] = lsb ? ins[k] : ins[15-k];
    for (int k = 0; k < 8; k++) word[7-k] = lsb ? wd[k] : wd[7-k];
    rd = 8'h00;
    chip_select_n = 1'b0;
    tick(6);
    for (int i = 23; i >= 0; i--) begin
      // Hand the line over once the instruction is out
      if (i < 8 && ins[15]) drv = 1'b0;
      bit_val = word[i];
      tick(6);
      rd = lsb ? {line, rd[7:1]} : {rd[6:0], line};
      sclk = 1'b1;
      tick(6);
      sclk = 1'b0;
    end
    tick(6);
    chip_select_n = 1'b1;
    drv = 1'b1;
    tick(8);
  endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the shadowed serial register map
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
  import spi_map_pkg::*;
  // Arbitrary value
  localparam logic [7:0] ID_VAL = 8'h3c;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk;
  logic chip_select_n;
  logic sdio_in;
  logic sdio_out;
  logic sdio_oe_n;
  bank_t active_a;
  bank_t active_b;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  logic lsb_mode = 1'b0;
  always #4 ref_clk = ~ref_clk;
  serial_register_map_shadow #(.CHIP_ID(ID_VAL), .SPEED_GRADE(2'h0)) i_serial_register_map_shadow (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .active_a(active_a), .active_b(active_b));
  spi_host i_spi_host (.ref_clk(ref_clk), .sclk(sclk), .chip_select_n(chip_select_n),
    .dev_out(sdio_out), .dev_oe_n(sdio_oe_n), .line(sdio_in));
  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_spi_host.frame({3'b000, a}, d, lsb_mode, r);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] r;
    i_spi_host.frame({3'b100, a}, 8'h00, lsb_mode, r);
    `CHK(r, e)
    `CHK(sdio_oe_n, 1'b1)
  endtask
  task automatic t_defaults();
    `CHK(active_a[1], 8'h01)
    `CHK(active_b[12], 8'h05)
    rd(13'h000, 8'h18);
    rd(13'h005, 8'h03);
    rd(13'h001, ID_VAL);
  endtask
  task automatic t_shadow();
    wr(13'h005, 8'h01);
    wr(13'h00b, 8'h5a);
    `CHK(active_a[3], 8'h00)
    rd(13'h00b, 8'h5a);
    wr(13'h0ff, 8'h01);
    `CHK(active_a[3], 8'h5a)
    `CHK(active_b[3], 8'h00)
    rd(13'h0ff, 8'h00);
  endtask
  task automatic t_both();
    wr(13'h005, 8'h03);
    wr(13'h00c, 8'h33);
    wr(13'h0ff, 8'h01);
    `CHK(active_a[4], 8'h33)
    `CHK(active_b[4], 8'h33)
    rd(13'h00b, 8'h5a);
    wr(13'h005, 8'h02);
    rd(13'h00b, 8'h00);
  endtask
  task automatic t_immediate();
    wr(13'h021, 8'h77);
    `CHK(active_b[25], 8'h77)
    `CHK(active_a[25], 8'h00)
    wr(13'h03c, 8'h11);
    `CHK(active_b[32], 8'h00)
    wr(13'h0ff, 8'h01);
    `CHK(active_b[32], 8'h11)
  endtask
  task automatic t_global();
    wr(13'h009, 8'h00);
    wr(13'h0ff, 8'h01);
    `CHK(active_a[1], 8'h00)
    `CHK(active_b[1], 8'h00)
    rd(13'h003, 8'h00);
  endtask
  task automatic t_order();
    wr(13'h000, 8'h5a);
    lsb_mode = 1'b1;
    rd(13'h000, 8'h5a);
    wr(13'h00d, 8'hc1);
    rd(13'h00d, 8'hc1);
    wr(13'h000, 8'h3c);
    lsb_mode = 1'b0;
    rd(13'h000, 8'h18);
    rd(13'h005, 8'h03);
    `CHK(active_a[1], 8'h01)
    `CHK(active_b[25], 8'h00)
  endtask
  task automatic t_reset();
    wr(13'h021, 8'h44);
    `CHK(active_a[25], 8'h44)
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(active_a[25], 8'h00)
    `CHK(active_b[12], 8'h05)
    rd(13'h005, 8'h03);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    t_defaults();
    t_shadow();
    t_both();
    t_immediate();
    t_global();
    t_order();
    t_reset();
    complete_run();
  end
endmodule
